/* loop_b_defs_pkg.sv */
`timescale 1ns/1ps
`default_nettype none

package loop_b_defs_pkg;

    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 8;

    // register offsets
    localparam logic [15:0] ADDR_ACTIVE     = 16'h0507;
    localparam logic [15:0] ADDR_LOOP_BAND  = 16'h0508;
    localparam logic [15:0] ADDR_QUICK_BAND = 16'h050e;
    localparam logic [15:0] ADDR_BAND_APPLY = 16'h0514;
    localparam logic [15:0] ADDR_NUM        = 16'h0515;
    localparam logic [15:0] ADDR_DEN        = 16'h051c;
    localparam logic [15:0] ADDR_FB_APPLY   = 16'h0520;
    localparam logic [15:0] ADDR_FRAC       = 16'h0521;

    // byte counts of the multi-byte fields and of the whole bank
    localparam int          BAND_BYTES      = 6;
    localparam int          NUM_BYTES       = 7;
    localparam int          DEN_BYTES       = 4;
    localparam int          BANK_SIZE       = 26;

    // bank indices, counted from the first loop band byte
    localparam logic [4:0]  IDX_LOOP        = 5'h00;
    localparam logic [4:0]  IDX_QUICK       = 5'h06;
    localparam logic [4:0]  IDX_BAND_APPLY  = 5'h0c;
    localparam logic [4:0]  IDX_NUM         = 5'h0d;
    localparam logic [4:0]  IDX_DEN         = 5'h14;
    localparam logic [4:0]  IDX_FB_APPLY    = 5'h18;
    localparam logic [4:0]  IDX_FRAC        = 5'h19;

    // field positions
    localparam int          ACTIVE_LSB      = 6;
    localparam int          APPLY_BIT       = 0;
    localparam int          FRAC_STYLE_MSB  = 3;
    localparam int          FRAC_EN_BIT     = 4;
    localparam int          FRAC_RSVD_BIT   = 5;

    // reset values and the fraction read mask
    localparam logic [7:0]  BYTE_RESET      = 8'h00;
    localparam logic [1:0]  ACTIVE_RESET    = 2'h0;
    localparam logic [7:0]  FRAC_KEEP_MASK  = 8'h3f;

endpackage : loop_b_defs_pkg

`default_nettype wire

/* staged_commit.sv */
`timescale 1ns/1ps
`default_nettype none

module staged_commit #(
    parameter int           W         = 8,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pend,
    input  wire logic         commit,
    output logic      [W-1:0] op
);

    logic [W-1:0] op_r;
    logic [W-1:0] op_nxt;

    // operating copy moves only on commit
    assign op_nxt = commit ? pend : op_r;
    assign op     = op_r;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            op_r <= RESET_VAL;
        else
            op_r <= op_nxt;
    end

endmodule : staged_commit

`default_nettype wire

/* loop_b_config_registers.sv */
`timescale 1ns/1ps
`default_nettype none

module loop_b_config_registers
    import loop_b_defs_pkg::*;
#(
    parameter int BAND_W = 48,
    parameter int NUM_W  = 56,
    parameter int DEN_W  = 32
) (
    input  wire logic                           SYS_CLK,
    input  wire logic                           RESETN,
    input  wire logic [loop_b_defs_pkg::ADDR_W-1:0] REG_ADDR,
    input  wire logic                           REG_WR,
    input  wire logic                           REG_RD,
    input  wire logic [loop_b_defs_pkg::DATA_W-1:0] REG_WDATA,
    output logic      [loop_b_defs_pkg::DATA_W-1:0] REG_RDATA,
    output logic                                REG_RVALID,
    input  wire logic                           DEVICE_SOFT_RESET,
    input  wire logic                           LOOP_B_SOFT_RESET,
    input  wire logic                           AUTO_MODE,
    input  wire logic                           MANUAL_REG_CTRL,
    input  wire logic [1:0]                     MANUAL_REG_CHOICE,
    input  wire logic                           INPUT_CHOICE_PIN_HIGH,
    input  wire logic                           INPUT_CHOICE_PIN_LOW,
    input  wire logic [1:0]                     AUTO_CHOICE,
    input  wire logic                           AUTO_VALID,
    input  wire logic [BAND_W-1:0]              HOLDOVER_BAND_PARAMS_B_PEND,
    output logic      [1:0]                     ACTIVE_INPUT_B,
    output logic      [BAND_W-1:0]              LOOP_BAND_PARAMS_B,
    output logic      [BAND_W-1:0]              QUICK_SETTLE_BAND_PARAMS_B,
    output logic      [BAND_W-1:0]              HOLDOVER_BAND_PARAMS_B,
    output logic      [NUM_W-1:0]               FEEDBACK_NUMERATOR_B,
    output logic      [DEN_W-1:0]               FEEDBACK_DENOMINATOR_B,
    output logic      [3:0]                     FEEDBACK_FRAC_STYLE_B,
    output logic                                FEEDBACK_FRAC_ENABLE_B
);

    import loop_b_defs_pkg::*;

    // pending byte bank, 0x508 up to 0x521
    logic [7:0]        bank_r [0:BANK_SIZE-1];

    logic              band_apply_strobe_b_r;
    logic              band_apply_strobe_b_nxt;
    logic              feedback_apply_strobe_b_r;
    logic              feedback_apply_strobe_b_nxt;
    logic [1:0]        active_input_b_r;
    logic [1:0]        active_input_b_nxt;
    logic [7:0]        rdata_r;
    logic [7:0]        rdata_nxt;
    logic              rvalid_r;
    logic [3:0]        frac_style_r;
    logic              frac_enable_r;

    logic [15:0]       bank_offset;
    logic [4:0]        bank_idx;
    logic              in_bank;
    logic              hit_active;
    logic              hit_band_apply;
    logic              hit_fb_apply;
    logic              hit_frac;
    logic              bank_wr;
    logic              band_apply_wr;
    logic              fb_apply_wr;
    logic              band_commit;
    logic              fb_commit;
    logic [1:0]        manual_choice;
    logic [1:0]        pin_choice;
    logic [7:0]        bank_rd;
    logic [7:0]        frac_byte;

    logic [BAND_W-1:0] loop_band_pend;
    logic [BAND_W-1:0] quick_band_pend;
    logic [NUM_W-1:0]  num_pend;
    logic [DEN_W-1:0]  den_pend;
    logic [BAND_W-1:0] loop_band_op;
    logic [BAND_W-1:0] quick_band_op;
    logic [BAND_W-1:0] hold_band_op;
    logic [NUM_W-1:0]  num_op;
    logic [DEN_W-1:0]  den_op;

    // address decode
    assign bank_offset    = REG_ADDR - ADDR_LOOP_BAND;
    assign bank_idx       = bank_offset[4:0];
    assign in_bank        = (REG_ADDR >= ADDR_LOOP_BAND) && (REG_ADDR <= ADDR_FRAC);
    assign hit_active     = (REG_ADDR == ADDR_ACTIVE);
    assign hit_band_apply = (REG_ADDR == ADDR_BAND_APPLY);
    assign hit_fb_apply   = (REG_ADDR == ADDR_FB_APPLY);
    assign hit_frac       = (REG_ADDR == ADDR_FRAC);

    // strobe addresses hold no pending byte
    assign bank_wr        = REG_WR && in_bank && !hit_band_apply && !hit_fb_apply;
    assign band_apply_wr  = REG_WR && hit_band_apply && REG_WDATA[APPLY_BIT];
    assign fb_apply_wr    = REG_WR && hit_fb_apply && REG_WDATA[APPLY_BIT];

    // loop B soft reset deliberately absent from the bandwidth commit
    assign band_commit    = band_apply_strobe_b_r || DEVICE_SOFT_RESET;
    // either soft reset latches the feedback divider
    assign fb_commit      = feedback_apply_strobe_b_r || DEVICE_SOFT_RESET
                          || LOOP_B_SOFT_RESET;

    // a new write in the clearing cycle keeps the bit set
    assign band_apply_strobe_b_nxt     = band_apply_wr
                                       || (band_apply_strobe_b_r && 1'b0);
    assign feedback_apply_strobe_b_nxt = fb_apply_wr;

    // pin pair forms the input number, high pin as msb
    assign pin_choice     = {INPUT_CHOICE_PIN_HIGH, INPUT_CHOICE_PIN_LOW};
    assign manual_choice  = MANUAL_REG_CTRL ? MANUAL_REG_CHOICE : pin_choice;

    // automatic mode without a valid input keeps the last pick
    assign active_input_b_nxt = !AUTO_MODE ? manual_choice
                              : AUTO_VALID ? AUTO_CHOICE
                              : active_input_b_r;

    // pending vectors, least significant byte at the lowest address
    genvar g;
    generate
        for (g = 0; g < BAND_BYTES; g++)
        begin : g_band
            assign loop_band_pend[8*g +: 8]  = bank_r[int'(IDX_LOOP) + g];
            assign quick_band_pend[8*g +: 8] = bank_r[int'(IDX_QUICK) + g];
        end
        for (g = 0; g < NUM_BYTES; g++)
        begin : g_num
            assign num_pend[8*g +: 8] = bank_r[int'(IDX_NUM) + g];
        end
        for (g = 0; g < DEN_BYTES; g++)
        begin : g_den
            assign den_pend[8*g +: 8] = bank_r[int'(IDX_DEN) + g];
        end
    endgenerate

    assign frac_byte = bank_r[IDX_FRAC];

    // read mux
    assign bank_rd   = bank_r[bank_idx];
    assign rdata_nxt = hit_active     ? {active_input_b_r, 6'h00}
                     : hit_band_apply ? {7'h00, band_apply_strobe_b_r}
                     : hit_fb_apply   ? {7'h00, feedback_apply_strobe_b_r}
                     : hit_frac       ? (frac_byte & FRAC_KEEP_MASK)
                     : in_bank        ? bank_rd
                     : 8'h00;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            for (int i = 0; i < BANK_SIZE; i++)
                bank_r[i] <= BYTE_RESET;
        end
        else if (bank_wr)
        begin
            bank_r[bank_idx] <= REG_WDATA;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            band_apply_strobe_b_r     <= 1'b0;
            feedback_apply_strobe_b_r <= 1'b0;
            active_input_b_r          <= ACTIVE_RESET;
            rdata_r                   <= 8'h00;
            rvalid_r                  <= 1'b0;
        end
        else
        begin
            band_apply_strobe_b_r     <= band_apply_strobe_b_nxt;
            feedback_apply_strobe_b_r <= feedback_apply_strobe_b_nxt;
            active_input_b_r          <= active_input_b_nxt;
            rvalid_r                  <= REG_RD;
            if (REG_RD)
                rdata_r <= rdata_nxt;
        end
    end

    // fraction controls follow the divider commit
    always_ff @(posedge SYS_CLK)
    begin
        if (!RESETN)
        begin
            frac_style_r  <= 4'h0;
            frac_enable_r <= 1'b0;
        end
        else if (fb_commit)
        begin
            frac_style_r  <= frac_byte[FRAC_STYLE_MSB:0];
            frac_enable_r <= frac_byte[FRAC_EN_BIT];
        end
    end

    // separate operating copies behind each pending set
    staged_commit #(.W(BAND_W), .RESET_VAL('0)) u_loop_band (
        .clk    (SYS_CLK),
        .rst_n  (RESETN),
        .pend   (loop_band_pend),
        .commit (band_commit),
        .op     (loop_band_op)
    );

    staged_commit #(.W(BAND_W), .RESET_VAL('0)) u_quick_band (
        .clk    (SYS_CLK),
        .rst_n  (RESETN),
        .pend   (quick_band_pend),
        .commit (band_commit),
        .op     (quick_band_op)
    );

    staged_commit #(.W(BAND_W), .RESET_VAL('0)) u_hold_band (
        .clk    (SYS_CLK),
        .rst_n  (RESETN),
        .pend   (HOLDOVER_BAND_PARAMS_B_PEND),
        .commit (band_commit),
        .op     (hold_band_op)
    );

    staged_commit #(.W(NUM_W), .RESET_VAL('0)) u_num (
        .clk    (SYS_CLK),
        .rst_n  (RESETN),
        .pend   (num_pend),
        .commit (fb_commit),
        .op     (num_op)
    );

    staged_commit #(.W(DEN_W), .RESET_VAL('0)) u_den (
        .clk    (SYS_CLK),
        .rst_n  (RESETN),
        .pend   (den_pend),
        .commit (fb_commit),
        .op     (den_op)
    );

    // all outputs come straight from flip-flops
    assign REG_RDATA                  = rdata_r;
    assign REG_RVALID                 = rvalid_r;
    assign ACTIVE_INPUT_B             = active_input_b_r;
    assign LOOP_BAND_PARAMS_B         = loop_band_op;
    assign QUICK_SETTLE_BAND_PARAMS_B = quick_band_op;
    assign HOLDOVER_BAND_PARAMS_B     = hold_band_op;
    assign FEEDBACK_NUMERATOR_B       = num_op;
    assign FEEDBACK_DENOMINATOR_B     = den_op;
    assign FEEDBACK_FRAC_STYLE_B      = frac_style_r;
    assign FEEDBACK_FRAC_ENABLE_B     = frac_enable_r;

endmodule : loop_b_config_registers

`default_nettype wire

/* loop_b_config_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module loop_b_config_checker
    import loop_b_defs_pkg::*;
#(
    parameter int BAND_W = 48,
    parameter int NUM_W  = 56,
    parameter int DEN_W  = 32
) (
    input wire logic                                SYS_CLK,
    input wire logic                                RESETN,
    input wire logic [loop_b_defs_pkg::ADDR_W-1:0]  REG_ADDR,
    input wire logic                                REG_WR,
    input wire logic                                REG_RD,
    input wire logic [loop_b_defs_pkg::DATA_W-1:0]  REG_WDATA,
    input wire logic                                REG_RVALID,
    input wire logic                                DEVICE_SOFT_RESET,
    input wire logic                                LOOP_B_SOFT_RESET,
    input wire logic                                AUTO_MODE,
    input wire logic                                MANUAL_REG_CTRL,
    input wire logic [1:0]                          MANUAL_REG_CHOICE,
    input wire logic                                INPUT_CHOICE_PIN_HIGH,
    input wire logic                                INPUT_CHOICE_PIN_LOW,
    input wire logic [1:0]                          AUTO_CHOICE,
    input wire logic                                AUTO_VALID,
    input wire logic [BAND_W-1:0]                   HOLDOVER_BAND_PARAMS_B_PEND,
    input wire logic [1:0]                          ACTIVE_INPUT_B,
    input wire logic [BAND_W-1:0]                   LOOP_BAND_PARAMS_B,
    input wire logic [BAND_W-1:0]                   QUICK_SETTLE_BAND_PARAMS_B,
    input wire logic [BAND_W-1:0]                   HOLDOVER_BAND_PARAMS_B,
    input wire logic [NUM_W-1:0]                    FEEDBACK_NUMERATOR_B,
    input wire logic [DEN_W-1:0]                    FEEDBACK_DENOMINATOR_B
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    wire band_wr = REG_WR && REG_ADDR == ADDR_BAND_APPLY && REG_WDATA[APPLY_BIT];
    wire fb_wr   = REG_WR && REG_ADDR == ADDR_FB_APPLY && REG_WDATA[APPLY_BIT];
    wire hunt    = AUTO_MODE && !AUTO_VALID;
    // strobe set at one edge commits at the next, soft reset commits at its own edge
    property p_band_hold;
        !band_wr ##1 !DEVICE_SOFT_RESET |=> $stable({LOOP_BAND_PARAMS_B,
            QUICK_SETTLE_BAND_PARAMS_B, HOLDOVER_BAND_PARAMS_B});
    endproperty
    a_band_hold: assert property (p_band_hold) else $error("band copy moved");
    property p_band_commit;
        band_wr ##1 1'b1 |=> HOLDOVER_BAND_PARAMS_B == $past(HOLDOVER_BAND_PARAMS_B_PEND);
    endproperty
    a_band_commit: assert property (p_band_commit) else $error("band not committed");
    property p_div_hold;
        !fb_wr ##1 !(DEVICE_SOFT_RESET || LOOP_B_SOFT_RESET) |=>
            $stable({FEEDBACK_NUMERATOR_B, FEEDBACK_DENOMINATOR_B});
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("divider copy moved");
    property p_read_answer;
        REG_RD |=> REG_RVALID;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_act_pins;
        !AUTO_MODE && !MANUAL_REG_CTRL |=>
            ACTIVE_INPUT_B == $past({INPUT_CHOICE_PIN_HIGH, INPUT_CHOICE_PIN_LOW});
    endproperty
    a_act_pins: assert property (p_act_pins) else $error("pin choice lost");
    property p_act_reg;
        !AUTO_MODE && MANUAL_REG_CTRL |=> ACTIVE_INPUT_B == $past(MANUAL_REG_CHOICE);
    endproperty
    a_act_reg: assert property (p_act_reg) else $error("register choice lost");
    property p_act_auto;
        AUTO_MODE && AUTO_VALID |=> ACTIVE_INPUT_B == $past(AUTO_CHOICE);
    endproperty
    a_act_auto: assert property (p_act_auto) else $error("automatic pick lost");
    property p_act_hold;
        hunt |=> $stable(ACTIVE_INPUT_B);
    endproperty
    a_act_hold: assert property (p_act_hold) else $error("active input moved");
    c_band: cover property (band_wr);
    c_div: cover property (fb_wr);
    c_hunt: cover property (hunt ##1 hunt);
endmodule : loop_b_config_checker
bind loop_b_config_registers loop_b_config_checker #(.BAND_W(BAND_W), .NUM_W(NUM_W),
    .DEN_W(DEN_W)) checker_inst (.*);
`default_nettype wire

/* loop_b_config_registers_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (a), (b)); end end
module loop_b_config_registers_bench;
    import loop_b_defs_pkg::*;
    logic SYS_CLK = 1'b0, RESETN = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, REG_RVALID;
    logic DEVICE_SOFT_RESET = 1'b0, LOOP_B_SOFT_RESET = 1'b0, AUTO_MODE = 1'b0;
    logic MANUAL_REG_CTRL = 1'b0, AUTO_VALID = 1'b0, FEEDBACK_FRAC_ENABLE_B;
    logic INPUT_CHOICE_PIN_HIGH = 1'b0, INPUT_CHOICE_PIN_LOW = 1'b0;
    logic [1:0] MANUAL_REG_CHOICE = 2'h0, AUTO_CHOICE = 2'h0, ACTIVE_INPUT_B, act = 2'h0;
    logic [15:0] REG_ADDR = 16'h0000;
    logic [7:0] REG_WDATA = 8'h00, REG_RDATA, d, f;
    logic [3:0] FEEDBACK_FRAC_STYLE_B;
    logic [47:0] HOLDOVER_BAND_PARAMS_B_PEND = 48'h0, HOLDOVER_BAND_PARAMS_B;
    logic [47:0] LOOP_BAND_PARAMS_B, QUICK_SETTLE_BAND_PARAMS_B;
    logic [55:0] FEEDBACK_NUMERATOR_B;
    logic [31:0] FEEDBACK_DENOMINATOR_B, r, seed = 32'h0000a8e2;
    logic [191:0] pv;
    logic [143:0] bo = '0;
    logic [87:0] fo = '0;
    int error_cnt = 0;
    int cmp_count = 0;
    loop_b_config_registers DUT (.*);
    initial forever #4 SYS_CLK = ~SYS_CLK;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // no valid input in automatic mode keeps the last pick
    function automatic logic [1:0] exp_act(input logic [1:0] last);
        if (!AUTO_MODE)
            return MANUAL_REG_CTRL ? MANUAL_REG_CHOICE
                                   : {INPUT_CHOICE_PIN_HIGH, INPUT_CHOICE_PIN_LOW};
        return AUTO_VALID ? AUTO_CHOICE : last;
    endfunction : exp_act
    task automatic step();
        @(posedge SYS_CLK);
        #1;
    endtask : step
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        REG_ADDR = a;
        REG_WDATA = v;
        REG_WR = 1'b1;
        step();
        REG_WR = 1'b0;
        step();
    endtask : wr
    // read valid stands only for the cycle after the taken edge; read data holds until the next read
    task automatic rd(input logic [15:0] a);
        REG_ADDR = a;
        REG_RD = 1'b1;
        step();
        REG_RD = 1'b0;
        `CHK(REG_RVALID, 1'b1)
        d = REG_RDATA;
        step();
    endtask : rd
    task automatic pulse(input logic dev);
        DEVICE_SOFT_RESET = dev;
        LOOP_B_SOFT_RESET = !dev;
        step();
        DEVICE_SOFT_RESET = 1'b0;
        LOOP_B_SOFT_RESET = 1'b0;
    endtask : pulse
    task automatic chk_ops();
        `CHK({HOLDOVER_BAND_PARAMS_B, QUICK_SETTLE_BAND_PARAMS_B, LOOP_BAND_PARAMS_B}, bo)
        `CHK({FEEDBACK_DENOMINATOR_B, FEEDBACK_NUMERATOR_B}, fo)
    endtask : chk_ops
    // byte 12 is the band strobe, skipped so the pending set stays uncommitted
    task automatic new_pend();
        // divider words stored raw; the fixed prescaler is left to software
        pv = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        r = rnd();
        HOLDOVER_BAND_PARAMS_B_PEND = {r[15:0], rnd()};
        for (int i = 0; i < 24; i++)
        begin
            if (i != 12)
            begin
                wr(ADDR_LOOP_BAND + 16'(i), pv[8*i+:8]);
                rd(ADDR_LOOP_BAND + 16'(i));
                `CHK(d, pv[8*i+:8])
            end
        end
        chk_ops();
    endtask : new_pend
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        repeat (8) @(posedge SYS_CLK);
        #1;
        RESETN = 1'b1;
        for (int a = 16'h0506; a <= 16'h0522; a++)
        begin
            rd(16'(a));
            `CHK(d, 8'h00)
        end
        chk_ops();
        $display("test reset values done");
        for (int i = 0; i < 16; i++)
        begin
            r = rnd();
            {AUTO_VALID, AUTO_CHOICE, INPUT_CHOICE_PIN_HIGH, INPUT_CHOICE_PIN_LOW} = r[4:0];
            {MANUAL_REG_CHOICE, MANUAL_REG_CTRL, AUTO_MODE} = r[8:5];
            if (i > 13)
            begin
                AUTO_MODE = 1'b1;
                AUTO_VALID = 1'b0;
                AUTO_CHOICE = ~act;
            end
            // last two passes force automatic mode with no valid input, so the field must keep the last pick
            act = exp_act(act);
            wr(ADDR_ACTIVE, r[31:24]);
            `CHK(ACTIVE_INPUT_B, act)
            rd(ADDR_ACTIVE);
            `CHK(d[7:6], act)
        end
        $display("test active input done");
        repeat (3)
        begin
            new_pend();
            pulse(1'b0);
            fo = pv[191:104];
            chk_ops();
            wr(ADDR_BAND_APPLY, 8'hfe);
            chk_ops();
            wr(ADDR_BAND_APPLY, 8'h01);
            bo = {HOLDOVER_BAND_PARAMS_B_PEND, pv[95:0]};
            chk_ops();
            rd(ADDR_BAND_APPLY);
            `CHK(d, 8'h00)
            new_pend();
            r = rnd();
            // style 0xb and reserved bit set, as software must program them
            f = {r[7:6], 1'b1, r[4], 4'hb};
            wr(ADDR_FRAC, f);
            rd(ADDR_FRAC);
            `CHK(d, f & FRAC_KEEP_MASK)
            wr(ADDR_FB_APPLY, 8'h01);
            fo = pv[191:104];
            chk_ops();
            `CHK({FEEDBACK_FRAC_ENABLE_B, FEEDBACK_FRAC_STYLE_B}, f[4:0])
            rd(ADDR_FB_APPLY);
            `CHK(d, 8'h00)
            new_pend();
            pulse(1'b1);
            bo = {HOLDOVER_BAND_PARAMS_B_PEND, pv[95:0]};
            fo = pv[191:104];
            chk_ops();
        end
        $display("test commit paths done");
        report_and_stop();
    end
endmodule : loop_b_config_registers_bench
`default_nettype wire
